// ==== pkg/fps_map.vh ====
// Register map, reset values and limits of the feedback position scaling block
`ifndef FPS_MAP_VH
`define FPS_MAP_VH

// Register numbers on the parameter port
`define FPS_ADDR_POLES      16'h012e
`define FPS_ADDR_SHIFT      16'h0130
`define FPS_ADDR_RATIO      16'h0132
`define FPS_ADDR_PRIMARY    16'h064a
`define FPS_ADDR_OFFSET     16'h0652
`define FPS_ADDR_UNIT       16'h0658

// Reset values
`define FPS_RST_POLES       16'h0002
`define FPS_RST_SHIFT       8'h14
`define FPS_RST_RATIO       16'h01f4
`define FPS_RST_OFFSET      64'h0000000000000000
`define FPS_RST_UNIT        32'h00000000

// Accepted ranges
`define FPS_POLES_MIN       16'h0002
`define FPS_POLES_MAX       16'h0080
`define FPS_SHIFT_MAX       8'h20
`define FPS_RATIO_MIN       16'h0001
`define FPS_RATIO_MAX       16'hc350

// Position unit codes
`define FPS_UNIT_COUNTS     32'h00000000
`define FPS_UNIT_RATIO      32'h00000003

// Width of the within-turn angle field
`define FPS_TURN_BITS       7'h20

`endif

// ==== verilog/fps_fieldbus_scale.v ====
// Reduces a 64-bit turns.angle position to a 32-bit fieldbus value
`include "fps_map.vh"

module fps_fieldbus_scale #(
    parameter POS_W = 64,
    parameter OUT_W = 32
) (
    input  wire             clock_i,
    input  wire             reset_n_i,
    input  wire [POS_W-1:0] position_i,
    input  wire [7:0]       shift_i,
    output wire [OUT_W-1:0] scaled_o
);

    reg  [OUT_W-1:0] scaled_ff;
    wire [6:0]       amount;
    wire [POS_W-1:0] shifted;

    // Shift setting is held within 0..32 by the register checks
    assign amount  = `FPS_TURN_BITS - {1'b0, shift_i[5:0]};
    assign shifted = position_i >> amount;

    always @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            scaled_ff <= {OUT_W{1'b0}};
        end else begin
            scaled_ff <= shifted[OUT_W-1:0];
        end
    end

    assign scaled_o = scaled_ff;

endmodule

// ==== verilog/fps_pole_check.v ====
// Tests by repeated subtraction whether motor poles are a multiple of feedback poles
module fps_pole_check #(
    parameter POLE_W = 16
) (
    input  wire              clock_i,
    input  wire              reset_n_i,
    input  wire              start_i,
    input  wire [POLE_W-1:0] motor_poles_i,
    input  wire [POLE_W-1:0] fb_poles_i,
    output wire              done_o,
    output wire              integer_o
);

    reg              busy_ff;
    reg              done_ff;
    reg              integer_ff;
    reg [POLE_W-1:0] rem_ff;
    reg [POLE_W-1:0] div_ff;

    always @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            busy_ff    <= 1'b0;
            done_ff    <= 1'b0;
            integer_ff <= 1'b0;
            rem_ff     <= {POLE_W{1'b0}};
            div_ff     <= {POLE_W{1'b0}};
        end else begin
            done_ff <= 1'b0;
            if (start_i && !busy_ff) begin
                busy_ff <= 1'b1;
                rem_ff  <= motor_poles_i;
                div_ff  <= fb_poles_i;
            end else if (busy_ff) begin
                if (rem_ff >= div_ff) begin
                    rem_ff <= rem_ff - div_ff;
                end else begin
                    busy_ff    <= 1'b0;
                    done_ff    <= 1'b1;
                    integer_ff <= (rem_ff == {POLE_W{1'b0}});
                end
            end
        end
    end

    assign done_o    = done_ff;
    assign integer_o = integer_ff;

endmodule

// ==== verilog/fps_top.v ====
// Primary feedback position offset, fieldbus scaling, pole check and settings
`include "fps_map.vh"

module fps_top #(
    parameter POS_W  = 64,
    parameter FB_W   = 32,
    parameter POLE_W = 16
) (
    input  wire              clock_i,
    input  wire              reset_n_i,
    input  wire [15:0]       reg_addr_i,
    input  wire              reg_wr_i,
    input  wire              reg_rd_i,
    input  wire [63:0]       reg_wdata_i,
    output wire [63:0]       reg_rdata_o,
    output wire              reg_ack_o,
    output wire              reg_err_o,
    input  wire [POS_W-1:0]  raw_position_i,
    input  wire [POS_W-1:0]  following_error_i,
    input  wire [POLE_W-1:0] motor_pole_count_i,
    input  wire              enable_request_i,
    input  wire              disable_request_i,
    input  wire              fault_clear_i,
    output wire [POS_W-1:0]  primary_position_o,
    output wire [FB_W-1:0]   position_actual_o,
    output wire [FB_W-1:0]   following_error_actual_o,
    output wire [1:0]        position_unit_code_o,
    output wire [15:0]       excitation_amplitude_o,
    output wire              drive_enabled_o,
    output wire              pole_fault_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Enable sequencing states
    localparam ST_IDLE  = 2'b00;
    localparam ST_CHECK = 2'b01;
    localparam ST_RUN   = 2'b10;
    localparam ST_FAULT = 2'b11;

    ////////////////////////////////////////////////////////////////////////////
    // Settings and state
    reg [POLE_W-1:0] poles_ff;
    reg [7:0]        shift_ff;
    reg [15:0]       ratio_ff;
    reg [POS_W-1:0]  offset_ff;
    reg [31:0]       unit_ff;
    reg [POS_W-1:0]  primary_ff;
    reg [63:0]       rdata_ff;
    reg              ack_ff;
    reg              err_ff;
    reg [1:0]        unit_out_ff;
    reg [15:0]       amp_ff;
    reg [1:0]        state_ff;
    reg [1:0]        nxt_state;
    reg              enabled_ff;
    reg              fault_ff;
    reg              nxt_fault;
    reg              start_ff;

    reg [63:0]       nxt_rdata;
    reg              nxt_err;
    reg              wr_poles;
    reg              wr_shift;
    reg              wr_ratio;
    reg              wr_offset;
    reg              wr_unit;

    wire             check_done;
    wire             check_integer;
    wire [FB_W-1:0]  scaled [0:1];
    wire [POS_W-1:0] scale_src [0:1];

    ////////////////////////////////////////////////////////////////////////////
    // Parameter port decode with range checks
    always @* begin
        nxt_rdata = 64'h0000000000000000;
        nxt_err   = 1'b0;
        wr_poles  = 1'b0;
        wr_shift  = 1'b0;
        wr_ratio  = 1'b0;
        wr_offset = 1'b0;
        wr_unit   = 1'b0;
        case (reg_addr_i)
            `FPS_ADDR_POLES: begin
                nxt_rdata = {{(64-POLE_W){1'b0}}, poles_ff};
                if (reg_wr_i) begin
                    if (reg_wdata_i >= {48'h000000000000, `FPS_POLES_MIN} &&
                        reg_wdata_i <= {48'h000000000000, `FPS_POLES_MAX}) begin
                        wr_poles = 1'b1;
                    end else begin
                        nxt_err = 1'b1;
                    end
                end
            end
            `FPS_ADDR_SHIFT: begin
                nxt_rdata = {56'h00000000000000, shift_ff};
                if (reg_wr_i) begin
                    if (reg_wdata_i <= {56'h00000000000000, `FPS_SHIFT_MAX}) begin
                        wr_shift = 1'b1;
                    end else begin
                        nxt_err = 1'b1;
                    end
                end
            end
            `FPS_ADDR_RATIO: begin
                nxt_rdata = {48'h000000000000, ratio_ff};
                if (reg_wr_i) begin
                    if (reg_wdata_i >= {48'h000000000000, `FPS_RATIO_MIN} &&
                        reg_wdata_i <= {48'h000000000000, `FPS_RATIO_MAX}) begin
                        wr_ratio = 1'b1;
                    end else begin
                        nxt_err = 1'b1;
                    end
                end
            end
            `FPS_ADDR_PRIMARY: begin
                nxt_rdata = primary_ff;
                if (reg_wr_i) begin
                    nxt_err = 1'b1;
                end
            end
            `FPS_ADDR_OFFSET: begin
                nxt_rdata = offset_ff;
                if (reg_wr_i) begin
                    wr_offset = 1'b1;
                end
            end
            `FPS_ADDR_UNIT: begin
                nxt_rdata = {32'h00000000, unit_ff};
                if (reg_wr_i) begin
                    if (reg_wdata_i == {32'h00000000, `FPS_UNIT_COUNTS} ||
                        reg_wdata_i == {32'h00000000, `FPS_UNIT_RATIO}) begin
                        wr_unit = 1'b1;
                    end else begin
                        nxt_err = 1'b1;
                    end
                end
            end
            default: begin
                nxt_err = reg_wr_i | reg_rd_i;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Setting registers and bus answer
    always @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            poles_ff  <= `FPS_RST_POLES;
            shift_ff  <= `FPS_RST_SHIFT;
            ratio_ff  <= `FPS_RST_RATIO;
            offset_ff <= `FPS_RST_OFFSET;
            unit_ff   <= `FPS_RST_UNIT;
            rdata_ff  <= 64'h0000000000000000;
            ack_ff    <= 1'b0;
            err_ff    <= 1'b0;
        end else begin
            if (wr_poles) begin
                poles_ff <= reg_wdata_i[POLE_W-1:0];
            end
            if (wr_shift) begin
                shift_ff <= reg_wdata_i[7:0];
            end
            if (wr_ratio) begin
                ratio_ff <= reg_wdata_i[15:0];
            end
            if (wr_offset) begin
                offset_ff <= reg_wdata_i[POS_W-1:0];
            end
            if (wr_unit) begin
                unit_ff <= reg_wdata_i[31:0];
            end
            ack_ff   <= reg_wr_i | reg_rd_i;
            err_ff   <= nxt_err;
            rdata_ff <= reg_rd_i ? nxt_rdata : 64'h0000000000000000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Offset position and derived outputs
    always @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            primary_ff  <= {POS_W{1'b0}};
            unit_out_ff <= 2'b00;
            amp_ff      <= `FPS_RST_RATIO;
        end else begin
            primary_ff  <= raw_position_i + offset_ff;
            unit_out_ff <= unit_ff[1:0];
            amp_ff      <= ratio_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Fieldbus reduction of actual position and following error
    assign scale_src[0] = primary_ff;
    assign scale_src[1] = following_error_i;

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch = ch + 1) begin : g_scale
            fps_fieldbus_scale #(
                .POS_W (POS_W),
                .OUT_W (FB_W)
            ) u_scale (
                .clock_i    (clock_i),
                .reset_n_i  (reset_n_i),
                .position_i (scale_src[ch]),
                .shift_i    (shift_ff),
                .scaled_o   (scaled[ch])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Enable sequence with pole ratio check
    fps_pole_check #(
        .POLE_W (POLE_W)
    ) u_pole_check (
        .clock_i       (clock_i),
        .reset_n_i     (reset_n_i),
        .start_i       (start_ff),
        .motor_poles_i (motor_pole_count_i),
        .fb_poles_i    (poles_ff),
        .done_o        (check_done),
        .integer_o     (check_integer)
    );

    always @* begin
        nxt_state = state_ff;
        nxt_fault = fault_ff;
        if (fault_clear_i) begin
            nxt_fault = 1'b0;
        end
        case (state_ff)
            ST_IDLE: begin
                if (enable_request_i) begin
                    nxt_state = ST_CHECK;
                end
            end
            ST_CHECK: begin
                if (check_done) begin
                    if (check_integer) begin
                        nxt_state = ST_RUN;
                    end else begin
                        nxt_state = ST_FAULT;
                        nxt_fault = 1'b1;
                    end
                end
            end
            ST_RUN: begin
                if (disable_request_i) begin
                    nxt_state = ST_IDLE;
                end
            end
            ST_FAULT: begin
                if (fault_clear_i) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    always @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_ff   <= ST_IDLE;
            fault_ff   <= 1'b0;
            enabled_ff <= 1'b0;
            start_ff   <= 1'b0;
        end else begin
            state_ff   <= nxt_state;
            fault_ff   <= nxt_fault;
            enabled_ff <= (nxt_state == ST_RUN);
            start_ff   <= (state_ff == ST_IDLE) && enable_request_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign reg_rdata_o              = rdata_ff;
    assign reg_ack_o                = ack_ff;
    assign reg_err_o                = err_ff;
    assign primary_position_o       = primary_ff;
    assign position_actual_o        = scaled[0];
    assign following_error_actual_o = scaled[1];
    assign position_unit_code_o     = unit_out_ff;
    assign excitation_amplitude_o   = amp_ff;
    assign drive_enabled_o          = enabled_ff;
    assign pole_fault_o             = fault_ff;

endmodule

// ==== bench/fps_checker.sv ====
// Concurrent checks on the ports of the feedback position scaling top
module fps_checker #(
    parameter POS_W  = 64,
    parameter FB_W   = 32,
    parameter POLE_W = 16
) (
    input logic              clock_i,
    input logic              reset_n_i,
    input logic [15:0]       reg_addr_i,
    input logic              reg_wr_i,
    input logic              reg_rd_i,
    input logic [63:0]       reg_wdata_i,
    input logic [63:0]       reg_rdata_o,
    input logic              reg_ack_o,
    input logic              reg_err_o,
    input logic [POS_W-1:0]  raw_position_i,
    input logic [POS_W-1:0]  following_error_i,
    input logic [POLE_W-1:0] motor_pole_count_i,
    input logic              enable_request_i,
    input logic              disable_request_i,
    input logic              fault_clear_i,
    input logic [POS_W-1:0]  primary_position_o,
    input logic [FB_W-1:0]   position_actual_o,
    input logic [FB_W-1:0]   following_error_actual_o,
    input logic [1:0]        position_unit_code_o,
    input logic [15:0]       excitation_amplitude_o,
    input logic              drive_enabled_o,
    input logic              pole_fault_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);
    logic [7:0]  shift_ff;
    logic [15:0] poles_ff;
    logic [15:0] ratio_ff;
    logic [63:0] offset_ff;
    logic [1:0]  quiet_ff;
    ////////////////////////////////////////
    // Shadow copies of accepted settings
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            shift_ff  <= 8'h14;
            poles_ff  <= 16'h0002;
            ratio_ff  <= 16'h01f4;
            offset_ff <= 64'h0;
            quiet_ff  <= 2'h0;
        end else begin
            if (reg_wr_i && reg_addr_i == 16'h0130 && reg_wdata_i <= 64'h20)
                shift_ff <= reg_wdata_i[7:0];
            if (reg_wr_i && reg_addr_i == 16'h012e && reg_wdata_i >= 64'h2 && reg_wdata_i <= 64'h80)
                poles_ff <= reg_wdata_i[15:0];
            if (reg_wr_i && reg_addr_i == 16'h0132 && reg_wdata_i >= 64'h1 && reg_wdata_i <= 64'hc350)
                ratio_ff <= reg_wdata_i[15:0];
            if (reg_wr_i && reg_addr_i == 16'h0652)
                offset_ff <= reg_wdata_i;
            quiet_ff <= reg_wr_i ? 2'h0 : (quiet_ff == 2'h3 ? 2'h3 : quiet_ff + 2'h1);
        end
    end
    function automatic logic [31:0] reduce(input logic [63:0] pos, input logic [7:0] sh);
        reduce = 32'(pos >> (8'd32 - sh));
    endfunction
    ////////////////////////////////////////
    // Properties
    sequence s_enable_req;
        enable_request_i && !drive_enabled_o && !pole_fault_o;
    endsequence
    sequence s_resolved;
        ##[1:300] (drive_enabled_o || pole_fault_o);
    endsequence
    property p_enable_resolves; s_enable_req |-> s_resolved; endproperty
    property p_enabled_divides; $rose(drive_enabled_o) |-> motor_pole_count_i % poles_ff == 0;
    endproperty
    property p_fault_nondivides; $rose(pole_fault_o) |-> motor_pole_count_i % poles_ff != 0;
    endproperty
    property p_unit_refused;
        reg_wr_i && reg_addr_i == 16'h0658 && reg_wdata_i != 64'h0 && reg_wdata_i != 64'h3
            |=> reg_ack_o && reg_err_o && $stable(position_unit_code_o);
    endproperty
    property p_poles_range;
        reg_wr_i && reg_addr_i == 16'h012e && (reg_wdata_i < 64'h2 || reg_wdata_i > 64'h80)
            |=> reg_ack_o && reg_err_o;
    endproperty
    property p_shift_range;
        reg_wr_i && reg_addr_i == 16'h0130 && reg_wdata_i > 64'h20 |=> reg_ack_o && reg_err_o;
    endproperty
    property p_primary_ro; reg_wr_i && reg_addr_i == 16'h064a |=> reg_err_o; endproperty
    property p_offset_sum;
        quiet_ff == 2'h3 |-> primary_position_o == $past(raw_position_i) + offset_ff;
    endproperty
    property p_fb_position;
        quiet_ff == 2'h3 |-> position_actual_o == reduce($past(primary_position_o), shift_ff);
    endproperty
    property p_fb_following;
        quiet_ff == 2'h3 |-> following_error_actual_o == reduce($past(following_error_i), shift_ff);
    endproperty
    property p_amplitude; quiet_ff == 2'h3 |-> excitation_amplitude_o == ratio_ff; endproperty
    a_enable_resolves: assert property (p_enable_resolves) else $error("enable not resolved");
    a_enabled_divides: assert property (p_enabled_divides) else $error("bad enable");
    a_fault_nondivides: assert property (p_fault_nondivides) else $error("bad fault");
    a_unit_refused: assert property (p_unit_refused) else $error("unit accepted");
    a_poles_range: assert property (p_poles_range) else $error("poles accepted");
    a_shift_range: assert property (p_shift_range) else $error("shift accepted");
    a_primary_ro: assert property (p_primary_ro) else $error("primary written");
    a_offset_sum: assert property (p_offset_sum) else $error("primary wrong");
    a_fb_position: assert property (p_fb_position) else $error("position object wrong");
    a_fb_following: assert property (p_fb_following) else $error("error object wrong");
    a_amplitude: assert property (p_amplitude) else $error("amplitude wrong");
endmodule

bind fps_top fps_checker #(.POS_W(POS_W), .FB_W(FB_W), .POLE_W(POLE_W)) u_checker (
    .clock_i(clock_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .reg_ack_o(reg_ack_o), .reg_err_o(reg_err_o), .raw_position_i(raw_position_i),
    .following_error_i(following_error_i), .motor_pole_count_i(motor_pole_count_i),
    .enable_request_i(enable_request_i), .disable_request_i(disable_request_i),
    .fault_clear_i(fault_clear_i), .primary_position_o(primary_position_o),
    .position_actual_o(position_actual_o), .following_error_actual_o(following_error_actual_o),
    .position_unit_code_o(position_unit_code_o), .excitation_amplitude_o(excitation_amplitude_o),
    .drive_enabled_o(drive_enabled_o), .pole_fault_o(pole_fault_o));

// ==== bench/fps_fieldbus_ctrl.sv ====
// Fieldbus controller model that samples the scaled position objects
module fps_fieldbus_ctrl (
    input  wire logic        clock_i,
    input  wire logic [31:0] position_actual_i,
    input  wire logic [31:0] following_error_actual_i,
    output logic      [31:0] pdo_position_o,
    output logic      [31:0] pdo_following_error_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Cyclic capture of both objects
    always @(posedge clock_i) begin
        pdo_position_o        <= position_actual_i;
        pdo_following_error_o <= following_error_actual_i;
    end
endmodule

// ==== bench/test_feedback_position_scaling.sv ====
// Self-checking testbench for the feedback position scaling block
module test_feedback_position_scaling;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock_i, reset_n_i, reg_wr_i, reg_rd_i, reg_ack_o, reg_err_o, ack, err;
    logic        enable_request_i, disable_request_i, fault_clear_i, drive_enabled_o, pole_fault_o;
    logic [15:0] reg_addr_i, motor_pole_count_i, excitation_amplitude_o;
    logic [63:0] reg_wdata_i, reg_rdata_o, raw_position_i, following_error_i, primary_position_o;
    logic [63:0] rdata;
    logic [31:0] position_actual_o, following_error_actual_o, pdo_pos, pdo_fe;
    logic [1:0]  position_unit_code_o;
    int          n_errors, checked, cycles, i;
    logic [15:0] wa[15] = '{16'h12e, 16'h12e, 16'h12e, 16'h12e, 16'h130, 16'h130, 16'h130,
        16'h132, 16'h132, 16'h132, 16'h132, 16'h658, 16'h658, 16'h658, 16'h658};
    logic [63:0] wd[15] = '{1, 128, 129, 2, 33, 32, 0, 0, 50001, 50000, 1, 3, 1, 2, 0};
    logic [63:0] wb[15] = '{2, 128, 128, 2, 20, 32, 0, 500, 500, 50000, 1, 3, 3, 3, 0};
    logic        we[15] = '{1, 0, 1, 0, 1, 0, 0, 1, 1, 0, 0, 0, 1, 1, 0};
    logic [7:0]  sh[4]  = '{20, 16, 32, 0};
    logic [31:0] sx[4]  = '{32'h0231234a, 32'h00231234, 32'h1234abcd, 32'h00000023};
    fps_top u_dut (.clock_i(clock_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o), .reg_ack_o(reg_ack_o), .reg_err_o(reg_err_o),
        .raw_position_i(raw_position_i), .following_error_i(following_error_i),
        .motor_pole_count_i(motor_pole_count_i), .enable_request_i(enable_request_i),
        .disable_request_i(disable_request_i), .fault_clear_i(fault_clear_i),
        .primary_position_o(primary_position_o), .position_actual_o(position_actual_o),
        .following_error_actual_o(following_error_actual_o),
        .position_unit_code_o(position_unit_code_o),
        .excitation_amplitude_o(excitation_amplitude_o),
        .drive_enabled_o(drive_enabled_o), .pole_fault_o(pole_fault_o));
    fps_fieldbus_ctrl u_ctrl (.clock_i(clock_i), .position_actual_i(position_actual_o),
        .following_error_actual_i(following_error_actual_o),
        .pdo_position_o(pdo_pos), .pdo_following_error_o(pdo_fe));
    ////////////////////////////////////////
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic access(input logic wr, input logic [15:0] addr, input logic [63:0] data);
        @(negedge clock_i);
        reg_wr_i = wr;
        reg_rd_i = !wr;
        reg_addr_i = addr;
        reg_wdata_i = data;
        @(negedge clock_i);
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        ack = reg_ack_o;
        err = reg_err_o;
        rdata = reg_rdata_o;
        chk({63'h0, ack}, 64'h1);
    endtask
    task automatic try_enable(input logic [15:0] motor, input logic [15:0] fb, input logic [1:0] e);
        access(1'b1, 16'h012e, {48'h0, fb});
        motor_pole_count_i = motor;
        @(negedge clock_i);
        enable_request_i = 1'b1;
        @(negedge clock_i);
        enable_request_i = 1'b0;
        for (i = 0; i < 300 && drive_enabled_o !== 1'b1 && pole_fault_o !== 1'b1; i++)
            @(negedge clock_i);
        chk({62'h0, pole_fault_o, drive_enabled_o}, {62'h0, e});
        disable_request_i = 1'b1;
        fault_clear_i = 1'b1;
        @(negedge clock_i);
        disable_request_i = 1'b0;
        fault_clear_i = 1'b0;
        repeat (2) @(negedge clock_i);
        chk({62'h0, pole_fault_o, drive_enabled_o}, 64'h0);
    endtask
    task automatic tally_and_finish;
        $display("Comparisons %0d, mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    ////////////////////////////////////////
    initial begin
        clock_i = 1'b0;
        forever #2.5 clock_i = ~clock_i;
    end
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            tally_and_finish();
        end
    end
    initial begin
        {reg_wr_i, reg_rd_i, enable_request_i, disable_request_i, fault_clear_i} = 5'h0;
        reg_addr_i = 16'h0;
        reg_wdata_i = 64'h0;
        motor_pole_count_i = 16'h8;
        raw_position_i = 64'h2710;
        following_error_i = 64'h0;
        reset_n_i = 1'b0;
        repeat (3) @(negedge clock_i);
        reset_n_i = 1'b1;
        access(1'b0, 16'h012e, 64'h0); chk(rdata, 64'h2);
        access(1'b0, 16'h0130, 64'h0); chk(rdata, 64'h14);
        access(1'b0, 16'h0132, 64'h0); chk(rdata, 64'h1f4);
        access(1'b0, 16'h0658, 64'h0); chk(rdata, 64'h0);
        for (int k = 0; k < 15; k++) begin
            access(1'b1, wa[k], wd[k]); chk({63'h0, err}, {63'h0, we[k]});
            access(1'b0, wa[k], 64'h0); chk(rdata, wb[k]);
        end
        chk({48'h0, excitation_amplitude_o}, 64'h1);
        access(1'b1, 16'h0658, 64'h3);
        repeat (3) @(negedge clock_i);
        chk({62'h0, position_unit_code_o}, 64'h3);
        access(1'b1, 16'h0658, 64'h2); chk({63'h0, err}, 64'h1);
        repeat (3) @(negedge clock_i);
        chk({62'h0, position_unit_code_o}, 64'h3);
        access(1'b0, 16'h0100, 64'h0); chk({63'h0, err}, 64'h1);
        access(1'b1, 16'h064a, 64'h5); chk({63'h0, err}, 64'h1);
        access(1'b1, 16'h0652, 64'hffffffffffffd8f0);
        repeat (4) @(negedge clock_i);
        chk(primary_position_o, 64'h0);
        access(1'b0, 16'h064a, 64'h0); chk(rdata, 64'h0);
        access(1'b1, 16'h0652, 64'h0);
        raw_position_i = 64'h000000231234abcd;
        following_error_i = 64'h000000231234abcd;
        for (int k = 0; k < 4; k++) begin
            access(1'b1, 16'h0130, {56'h0, sh[k]});
            repeat (4) @(negedge clock_i);
            chk({32'h0, position_actual_o}, {32'h0, sx[k]});
            chk({32'h0, pdo_pos}, {32'h0, sx[k]});
            chk({32'h0, pdo_fe}, {32'h0, sx[k]});
        end
        following_error_i = 64'h0000004500000000;
        access(1'b1, 16'h0652, 64'h0000000100000000);
        repeat (4) @(negedge clock_i);
        chk(primary_position_o, 64'h000000241234abcd);
        chk({32'h0, position_actual_o}, 64'h24);
        chk({32'h0, following_error_actual_o}, 64'h45);
        chk({32'h0, pdo_fe}, 64'h45);
        try_enable(16'h8, 16'h2, 2'b01);
        try_enable(16'h8, 16'h3, 2'b10);
        try_enable(16'h80, 16'h80, 2'b01);
        try_enable(16'hc, 16'h8, 2'b10);
        tally_and_finish();
    end
endmodule
